// *** core/oscsel_regs.svh ***
// Register map, field positions and reset values of the oscillator select block.
// Assumes a 32-bit classic Wishbone slave holding the one byte-wide control register.
// Function
// - Control bit 7 resets to zero, and writing one stops the subclock oscillator while zero lets it run.
// - Bit 6 is read-only and always reads zero.
// - Bits 5 to 3 reset to zero and read back whatever software last wrote.
// - Read-only bit 2 shows the strap pin level captured during reset.
// - Read-only bit 1 shows the active source: zero for the resonator oscillator, one for the on-chip oscillator.
// - The strap level picks the source: zero enables the resonator oscillator, one enables the on-chip one.
// - Watchdog and low-voltage resets leave the source selection unchanged.
`ifndef OSCSEL_REGS_SVH
`define OSCSEL_REGS_SVH

`define OSCSEL_ADDR_W        8
`define OSCSEL_DATA_W        32
`define OSCSEL_CTRL_ADDR     8'h00
`define OSCSEL_SUB_STOP_BIT  7
`define OSCSEL_RSVD_RO_BIT   6
`define OSCSEL_RSVD_RW_HI    5
`define OSCSEL_RSVD_RW_LO    3
`define OSCSEL_STRAP_BIT     2
`define OSCSEL_SRC_BIT       1
`define OSCSEL_RSVD0_BIT     0
`define OSCSEL_BIT_RST       1'h0
`define OSCSEL_RSVD_RW_RST   3'h0
`define OSCSEL_FLAG_RST      1'h0
`define OSCSEL_ZERO_WORD     32'h0000_0000

`endif

// *** core/oscsel_pkg.sv ***
// Types shared by the oscillator select block.
// Assumes nothing of its surroundings.
package oscsel_pkg;

  // Gray coded: capture then hold
  typedef enum logic [1:0] {
    OSCSEL_ST_CAPTURE = 2'b00,
    OSCSEL_ST_HOLD    = 2'b01
  } oscsel_state_t;

endpackage

// *** core/oscsel_sync.sv ***
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the clock runs while reset is held, so the level is known at release.
`timescale 1ns/1ns
`default_nettype none

module oscsel_sync (
  input  wire logic clk_in,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta_q;

  // No reset: must track the strap while the device sits in reset
  always_ff @(posedge clk_in) begin
    meta_q   <= async_in;
    sync_out <= meta_q;
  end

endmodule

`default_nettype wire

// *** core/oscsel_ctrl.sv ***
// Oscillator select control: strap capture, source enables, control register on Wishbone.
// Assumes rst_b_in is asserted for every reset and cold_rst_b_in only for qualifying ones.
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "oscsel_regs.svh"

module oscsel_ctrl (
  input  wire logic                        clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic                        cold_rst_b_in,
  input  wire logic                        clock_select_strap_pin_in,
  input  wire logic                        wb_cyc_in,
  input  wire logic                        wb_stb_in,
  input  wire logic                        wb_we_in,
  input  wire logic [`OSCSEL_ADDR_W-1:0]   wb_adr_in,
  input  wire logic [3:0]                  wb_sel_in,
  input  wire logic [`OSCSEL_DATA_W-1:0]   wb_dat_in,
  output var  logic [`OSCSEL_DATA_W-1:0]   wb_dat_out,
  output var  logic                        wb_ack_out,
  output var  logic                        sys_osc_en_out,
  output var  logic                        onchip_osc_en_out,
  output var  logic                        sub_osc_run_out
);

  oscsel_pkg::oscsel_state_t state_q;

  logic                      strap_sync;
  logic                      sub_oscillator_stop_q;
  logic [2:0]                rsvd_rw_q;
  logic                      rsvd0_q;
  logic                      strap_level_flag_q;
  logic                      clock_source_flag_q;
  logic                      ack_q;
  logic [`OSCSEL_DATA_W-1:0] dat_q;
  logic [`OSCSEL_DATA_W-1:0] reg_val;
  logic                      req;
  logic                      hit;
  logic                      wr_fire;

  oscsel_sync u_strap_sync (
    .clk_in   (clk_in),
    .async_in (clock_select_strap_pin_in),
    .sync_out (strap_sync)
  );

  // Only qualifying resets clear the flags; warm resets leave them alone
  always_ff @(posedge clk_in or negedge cold_rst_b_in) begin
    if (!cold_rst_b_in) begin
      state_q             <= oscsel_pkg::OSCSEL_ST_CAPTURE;
      strap_level_flag_q  <= `OSCSEL_FLAG_RST;
      clock_source_flag_q <= `OSCSEL_FLAG_RST;
    end else begin
      unique case (state_q)
        oscsel_pkg::OSCSEL_ST_CAPTURE: begin
          strap_level_flag_q  <= strap_sync;
          clock_source_flag_q <= strap_sync;
          state_q             <= oscsel_pkg::OSCSEL_ST_HOLD;
        end
        oscsel_pkg::OSCSEL_ST_HOLD: begin
          state_q <= oscsel_pkg::OSCSEL_ST_HOLD;
        end
      endcase
    end
  end

  assign sys_osc_en_out    = ~clock_source_flag_q;
  assign onchip_osc_en_out = clock_source_flag_q;
  assign sub_osc_run_out   = ~sub_oscillator_stop_q;

  assign req     = wb_cyc_in & wb_stb_in;
  assign hit     = (wb_adr_in == `OSCSEL_CTRL_ADDR);
  // Write lands on the edge where the master sees ack
  assign wr_fire = req & ack_q & wb_we_in & hit & wb_sel_in[0];

  // Any reset, warm ones too, lets the subclock run again
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sub_oscillator_stop_q <= `OSCSEL_BIT_RST;
    end else if (wr_fire) begin
      sub_oscillator_stop_q <= wb_dat_in[`OSCSEL_SUB_STOP_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsvd_rw_q <= `OSCSEL_RSVD_RW_RST;
    end else if (wr_fire) begin
      rsvd_rw_q <= wb_dat_in[`OSCSEL_RSVD_RW_HI:`OSCSEL_RSVD_RW_LO];
    end
  end

  // Stored as written; software is trusted to keep it zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsvd0_q <= `OSCSEL_BIT_RST;
    end else if (wr_fire) begin
      rsvd0_q <= wb_dat_in[`OSCSEL_RSVD0_BIT];
    end
  end

  always_comb begin
    reg_val                                        = `OSCSEL_ZERO_WORD;
    reg_val[`OSCSEL_SUB_STOP_BIT]                  = sub_oscillator_stop_q;
    reg_val[`OSCSEL_RSVD_RO_BIT]                   = 1'b0;
    reg_val[`OSCSEL_RSVD_RW_HI:`OSCSEL_RSVD_RW_LO] = rsvd_rw_q;
    reg_val[`OSCSEL_STRAP_BIT]                     = strap_level_flag_q;
    reg_val[`OSCSEL_SRC_BIT]                       = clock_source_flag_q;
    reg_val[`OSCSEL_RSVD0_BIT]                     = rsvd0_q;
  end

  // One wait state; unmapped addresses ack with zero and drop writes
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dat_q <= `OSCSEL_ZERO_WORD;
    end else if (req & ~ack_q) begin
      dat_q <= hit ? reg_val : `OSCSEL_ZERO_WORD;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = dat_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in || !cold_rst_b_in);

  sequence s_ctrl_write;
    wr_fire;
  endsequence

  sequence s_ctrl_read_start;
    req && !ack_q && hit && !wb_we_in;
  endsequence

  // Master drops cyc for one cycle between requests, so the read is taken two edges on
  sequence s_write_then_read;
    s_ctrl_write ##2 s_ctrl_read_start;
  endsequence

  // Release edge itself still sees the reset low, so capture is the edge after it
  sequence s_capture_edge;
    state_q == oscsel_pkg::OSCSEL_ST_CAPTURE && cold_rst_b_in;
  endsequence

  a_sub_stop_write: assert property (s_ctrl_write |=>
      sub_osc_run_out == !$past(wb_dat_in[`OSCSEL_SUB_STOP_BIT]))
    else $error("subclock run output does not follow written stop bit");

  a_sub_stop_idle: assert property (!wr_fire |=> $stable(sub_osc_run_out))
    else $error("subclock run output changed without a write");

  a_sub_stop_readback: assert property (s_write_then_read |=>
      wb_dat_out[`OSCSEL_SUB_STOP_BIT] == $past(wb_dat_in[`OSCSEL_SUB_STOP_BIT], 3))
    else $error("stop bit does not read back last write");

  a_ro_bit_zero: assert property (wb_ack_out |-> wb_dat_out[`OSCSEL_RSVD_RO_BIT] == 1'b0)
    else $error("reserved read-only bit read as one");

  a_rsvd_rw_readback: assert property (s_write_then_read |=>
      wb_dat_out[`OSCSEL_RSVD_RW_HI:`OSCSEL_RSVD_RW_LO] ==
      $past(wb_dat_in[`OSCSEL_RSVD_RW_HI:`OSCSEL_RSVD_RW_LO], 3))
    else $error("reserved bits do not read back last write");

  a_rsvd_rw_hold: assert property (!wr_fire |=> $stable(rsvd_rw_q))
    else $error("reserved bits changed without a write");

  a_strap_flag_read: assert property (wb_ack_out && hit |->
      wb_dat_out[`OSCSEL_STRAP_BIT] == strap_level_flag_q)
    else $error("strap flag read back wrong");

  a_strap_level_capture: assert property (s_capture_edge |=>
      strap_level_flag_q == $past(strap_sync))
    else $error("strap flag not taken from sampled pin");

  a_source_flag_read: assert property (wb_ack_out && hit |->
      wb_dat_out[`OSCSEL_SRC_BIT] == clock_source_flag_q && sys_osc_en_out != onchip_osc_en_out)
    else $error("source flag or oscillator enables wrong");

  a_strap_capture: assert property (s_capture_edge |=>
      clock_source_flag_q == $past(strap_sync) && onchip_osc_en_out == $past(strap_sync))
    else $error("source not chosen from sampled strap");

  a_enables_exclusive: assert property (sys_osc_en_out != onchip_osc_en_out)
    else $error("both or neither system oscillator enabled");

  a_warm_reset_keep: assert property (@(posedge clk_in) disable iff (!cold_rst_b_in)
      !rst_b_in |=> $stable(clock_source_flag_q) && $stable(strap_level_flag_q))
    else $error("warm reset changed source selection");

  a_warm_enable_keep: assert property (@(posedge clk_in) disable iff (!cold_rst_b_in)
      !rst_b_in |=> $stable(sys_osc_en_out) && $stable(onchip_osc_en_out))
    else $error("warm reset switched the system oscillator");

  a_flags_hold: assert property (state_q == oscsel_pkg::OSCSEL_ST_HOLD |=>
      $stable(strap_level_flag_q) && $stable(clock_source_flag_q) && state_q == oscsel_pkg::OSCSEL_ST_HOLD)
    else $error("flags changed after capture");

  a_capture_once: assert property (s_capture_edge |=>
      state_q == oscsel_pkg::OSCSEL_ST_HOLD)
    else $error("capture state held for more than one cycle");

  a_ack_single: assert property (req && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a single cycle after one wait");

  a_ack_needs_req: assert property (!req |=> !wb_ack_out)
    else $error("ack without a request");

  a_read_data_hold: assert property (wb_ack_out |=> $stable(wb_dat_out))
    else $error("read data changed right after ack");

  a_upper_read_zero: assert property (wb_ack_out |-> wb_dat_out[`OSCSEL_DATA_W-1:`OSCSEL_SUB_STOP_BIT+1] == '0)
    else $error("bits above the register read as nonzero");

  a_unmapped_zero: assert property (wb_ack_out && !hit |-> wb_dat_out == `OSCSEL_ZERO_WORD)
    else $error("unmapped address read nonzero");

endmodule

`default_nettype wire

// *** testbench/oscsel_strap_model.sv ***
// Board model of the clock select strap: a level tied to supply or ground.
// Assumes the bench names the wanted oscillator as each reset begins and keeps it there until release.
`timescale 1ns/1ns
`default_nettype none

module oscsel_strap_model (
  input  wire logic want_onchip_in,
  output var  logic strap_out
);
  // Hard strap, never floats; low keeps the resonator selected for flash work
  assign strap_out = want_onchip_in;
endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
// Bench for the oscillator select block: register bus, strap capture and both reset kinds.
// Assumes one 250 MHz clock and a strap model that holds its level through reset.
`timescale 1ns/1ns
`default_nettype none
`include "oscsel_regs.svh"

module tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cold_b = 1'b0;
  logic        want = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic        strap, ack, sys_en, chip_en, sub_run;
  logic [31:0] rdat, got;
  int          mismatches = 0;
  int          num_checks = 0;

  oscsel_strap_model u_oscsel_strap_model (.want_onchip_in(want), .strap_out(strap));

  oscsel_ctrl u_oscsel_ctrl (.clk_in(clk), .rst_b_in(rst_b), .cold_rst_b_in(cold_b),
    .clock_select_strap_pin_in(strap), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .sys_osc_en_out(sys_en), .onchip_osc_en_out(chip_en), .sub_osc_run_out(sub_run));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic wrap_up;
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Classic single cycle; called just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000, 4'h1);
    chk(got, e);
  endtask

  // Enables settle after the edge, so look at the falling edge
  task automatic pins(input logic s, input logic run);
    @(negedge clk);
    chk({29'h0, sys_en, chip_en, sub_run}, {29'h0, ~s, s, run});
    @(posedge clk);
  endtask

  // Cold reset resamples the strap; warm reset must not
  task automatic rst(input logic cold, input logic s);
    rst_b <= 1'b0;
    cold_b <= ~cold;
    want <= s;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    cold_b <= 1'b1;
    @(posedge clk);
  endtask

  initial begin
    @(posedge clk);
    rst(1'b1, 1'b0);
    pins(1'b0, 1'b1);
    rd(`OSCSEL_CTRL_ADDR, 32'h0000_0000);
    // Stop only in active mode, bit 0 kept clear
    wb(1'b1, `OSCSEL_CTRL_ADDR, 32'hffff_fffe, 4'h1);
    rd(`OSCSEL_CTRL_ADDR, 32'h0000_00b8);
    pins(1'b0, 1'b0);
    wb(1'b1, `OSCSEL_CTRL_ADDR, 32'h0000_0028, 4'h0);
    rd(`OSCSEL_CTRL_ADDR, 32'h0000_00b8);
    // Subclock restarted but never used afterwards, so no settling wait
    wb(1'b1, `OSCSEL_CTRL_ADDR, 32'h0000_0028, 4'h1);
    rd(`OSCSEL_CTRL_ADDR, 32'h0000_0028);
    pins(1'b0, 1'b1);
    wb(1'b1, 8'h10, 32'h0000_0080, 4'h1);
    rd(8'h10, 32'h0000_0000);
    rd(`OSCSEL_CTRL_ADDR, 32'h0000_0028);
    rst(1'b0, 1'b1);
    pins(1'b0, 1'b1);
    rd(`OSCSEL_CTRL_ADDR, 32'h0000_0000);
    rst(1'b1, 1'b1);
    pins(1'b1, 1'b1);
    rd(`OSCSEL_CTRL_ADDR, 32'h0000_0006);
    want <= 1'b0;
    repeat (8) @(posedge clk);
    rd(`OSCSEL_CTRL_ADDR, 32'h0000_0006);
    pins(1'b1, 1'b1);
    wrap_up;
  end

  // Run needs about 93 cycles
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    wrap_up;
  end
endmodule

`default_nettype wire
